// ---- cter_pkg.sv ----
// Package of constants, state codes and carrier structs for the charger thermal event block.
package cter_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h01;
  localparam logic [7:0] ADDR_CTRL2 = 8'h02;
  localparam logic [7:0] ADDR_CHG_CUR = 8'h03;
  localparam logic [7:0] ADDR_NTC_SET1 = 8'h04;
  localparam logic [7:0] ADDR_NTC_SET2 = 8'h05;
  localparam logic [7:0] ADDR_STAT_EVT = 8'h06;
  localparam logic [7:0] ADDR_CHG_EVT1 = 8'h07;
  localparam logic [7:0] ADDR_CHG_EVT2 = 8'h08;
  localparam logic [7:0] ADDR_BST_EVT = 8'h09;
  localparam logic [7:0] ADDR_STATE_EVENT_MASK_REG = 8'h0a;
  localparam logic [7:0] ADDR_CHG_MSK1 = 8'h0b;
  localparam logic [7:0] ADDR_CHG_MSK2 = 8'h0c;
  localparam logic [7:0] ADDR_BOOST_EVENT_MASK_REG = 8'h0d;
  localparam logic [7:0] ADDR_INPUT_SNS = 8'h0e;
  localparam logic [7:0] ADDR_BATT_SNS = 8'h0f;
  localparam logic [7:0] ADDR_TEMPERATURE_SENSE_REG = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL1_CHARGE_ENABLE_BIT = 0;
  localparam int CTRL1_FOLDBACK = 1;
  localparam int CTRL1_EXT_TEMP = 2;
  localparam int CTRL1_THERMISTOR_CHECK_ENABLE = 3;
  localparam int CTRL1_INT_MASK = 4;
  localparam int CTRL2_TRANS_EN = 0;
  localparam int STAT_FAULT_SUM = 7;
  localparam int STAT_STATUS_SUM = 6;
  localparam int STAT_NTC_PRES = 5;
  localparam int STAT_SW_PRES = 4;
  localparam int EVT1_BATT_RMV = 0;
  localparam int EVT1_DIE_WARN = 1;
  localparam int EVT1_DIE_M1 = 2;
  localparam int EVT1_DIE_M2 = 3;
  localparam int EVT1_NTC_CROSS = 4;
  localparam int EVT1_NTC_GONE = 5;
  localparam int EVT1_DIE_SD = 6;
  localparam int EVTS_STATE_CHG = 0;

  // ****************************************
  // Reset values and charge current scale
  // ****************************************
  localparam logic [7:0] CTRL1_RST = 8'h09;
  localparam logic [7:0] CTRL2_RST = 8'h01;
  localparam logic [7:0] CHG_CUR_RST = 8'h04;
  localparam logic [7:0] NTC_SET1_RST = 8'h00;
  localparam logic [7:0] NTC_SET2_RST = 8'h00;
  localparam logic [7:0] MSK_RST = 8'h00;
  localparam logic [3:0] CUR_MIN_CODE = 4'h0;
  localparam logic [3:0] CUR_FOLD_STEPS = 4'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int DEBOUNCE_US = 10;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1_000_000));
  localparam int PULSE_US = 100;
  localparam int PULSE_CYC = (PULSE_US * (CLK_HZ / 1_000_000));

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_CONFIG = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_DONE = 3'b100,
    ST_FAULT = 3'b101,
    ST_WEAK_WAIT = 3'b110,
    ST_DISABLED = 3'b111
  } chg_state_e;

  // Raw comparator outputs from the analog front end.
  typedef struct packed {
    logic vin_uv_ok;
    logic vin_ov;
    logic bat_present;
    logic charge_done;
    logic die_warn;
    logic die_m1;
    logic die_m2;
    logic die_sd;
    logic ntc_cold;
    logic ntc_chilly;
    logic ntc_warm;
    logic ntc_hot;
    logic ntc_removed;
    logic ntc_grounded;
    logic sw_detect;
  } comp_s;

  // Charge control outputs toward the power stage.
  typedef struct packed {
    logic charge_on;
    logic reduced_mode;
    logic [3:0] current_code;
    logic [3:0] voltage_code;
    logic trans_on;
  } chg_ctl_s;

endpackage

// ---- cter_debounce.sv ----
// Per-bit debounce filter whose stable outputs come from registers.
`timescale 1ns/100ps
`default_nettype none
module cter_debounce #(
  parameter int WIDTH = 15,
  parameter int COUNT = 500
) (
  input wire logic i_core_clk, // System clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic [WIDTH-1:0] i_raw, // Raw comparator levels.
  output logic [WIDTH-1:0] o_stable // Debounced levels.
);

  localparam int CW = $clog2(COUNT + 1);

  // One counter per bit; a level must hold COUNT cycles before it is accepted.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic [CW-1:0] cnt_r;
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          cnt_r <= '0;
          o_stable[g] <= 1'b0;
        end else if (i_raw[g] == o_stable[g]) begin
          cnt_r <= '0;
        end else if (cnt_r == CW'(COUNT - 1)) begin
          cnt_r <= '0;
          o_stable[g] <= i_raw[g];
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- cter_core.sv ----
// Charger thermal supervision, charge state tracking and event reporting.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cter_core
  import cter_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  input wire logic i_core_clk, // System clock, 50 MHz.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic [7:0] i_addr, // Register address.
  input wire logic [7:0] i_wdata, // Register write data.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  output logic [7:0] o_rdata, // Read data, valid one cycle after i_rd.
  input wire comp_s i_comp, // Raw comparator outputs.
  input wire logic [7:0] i_boost_evt, // Boost event pulses from boost logic.
  output chg_ctl_s o_ctl, // Charge control toward power stage.
  output logic o_flag, // Status interrupt pin level.
  output chg_state_e o_state // Current charge state code.
);

  // ****************************************
  // Debounce
  // ****************************************
  comp_s comp_db;
  cter_debounce #(
    .WIDTH($bits(comp_s)),
    .COUNT(DEBOUNCE_CYCLES)
  ) u_db (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_raw(i_comp),
    .o_stable(comp_db)
  );

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] ctrl1_r, ctrl2_r, chg_cur_r, ntc_set1_r, ntc_set2_r;
  logic [7:0] state_event_mask_reg_r, chg_msk1_r, chg_msk2_r, boost_event_mask_reg_r;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl1_r <= CTRL1_RST;
      ctrl2_r <= CTRL2_RST;
      chg_cur_r <= CHG_CUR_RST;
      ntc_set1_r <= NTC_SET1_RST;
      ntc_set2_r <= NTC_SET2_RST;
      state_event_mask_reg_r <= MSK_RST;
      chg_msk1_r <= MSK_RST;
      chg_msk2_r <= MSK_RST;
      boost_event_mask_reg_r <= MSK_RST;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_CTRL1: ctrl1_r <= i_wdata;
        ADDR_CTRL2: ctrl2_r <= i_wdata;
        ADDR_CHG_CUR: chg_cur_r <= i_wdata;
        ADDR_NTC_SET1: ntc_set1_r <= i_wdata;
        ADDR_NTC_SET2: ntc_set2_r <= i_wdata;
        ADDR_STATE_EVENT_MASK_REG: state_event_mask_reg_r <= i_wdata;
        ADDR_CHG_MSK1: chg_msk1_r <= i_wdata;
        ADDR_CHG_MSK2: chg_msk2_r <= i_wdata;
        ADDR_BOOST_EVENT_MASK_REG: boost_event_mask_reg_r <= i_wdata;
        default: ;
      endcase
    end
  end

  logic chg_enable, foldback_en, ext_scheme, ntc_check_en, global_mask;
  assign chg_enable = ctrl1_r[CTRL1_CHARGE_ENABLE_BIT];
  assign foldback_en = ctrl1_r[CTRL1_FOLDBACK];
  assign ext_scheme = ctrl1_r[CTRL1_EXT_TEMP];
  assign ntc_check_en = ctrl1_r[CTRL1_THERMISTOR_CHECK_ENABLE];
  assign global_mask = ctrl1_r[CTRL1_INT_MASK];

  // ****************************************
  // Battery temperature window
  // ****************************************
  // The comparator bits say the voltage is beyond each threshold: cold, chilly
  // are cold-side flags, warm, hot are hot-side flags.
  logic ntc_monitor, ntc_gone, out_of_temp, reduced_band;
  assign ntc_monitor = !comp_db.ntc_grounded;
  assign ntc_gone = ntc_monitor && ntc_check_en && comp_db.ntc_removed;

  always_comb begin
    out_of_temp = 1'b0;
    reduced_band = 1'b0;
    if (ntc_monitor) begin
      if (!ext_scheme) begin
        out_of_temp = comp_db.ntc_cold || comp_db.ntc_warm;
      end else begin
        out_of_temp = comp_db.ntc_cold || comp_db.ntc_hot;
        reduced_band = comp_db.ntc_chilly || comp_db.ntc_warm;
      end
    end
  end

  // ****************************************
  // Charge state machine
  // ****************************************
  chg_state_e state_r, state_nxt;
  logic ntc_present_r, sw_present_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: if (comp_db.vin_uv_ok && !comp_db.vin_ov) state_nxt = ST_CONFIG;
      ST_CONFIG: state_nxt = ST_WAIT;
      ST_WAIT: begin
        if (!chg_enable) state_nxt = ST_DISABLED;
        else if (comp_db.bat_present && !out_of_temp && !ntc_gone) state_nxt = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (comp_db.die_sd) state_nxt = ST_FAULT;
        else if (ntc_gone) state_nxt = ST_FAULT;
        else if (!chg_enable) state_nxt = ST_DISABLED;
        else if (out_of_temp) state_nxt = ST_WAIT;
        else if (comp_db.charge_done) state_nxt = ST_DONE;
      end
      ST_DONE: if (!chg_enable) state_nxt = ST_DISABLED;
      ST_FAULT: if (ntc_gone && sw_present_r) state_nxt = ST_WEAK_WAIT;
      ST_WEAK_WAIT: if (!ntc_gone && comp_db.bat_present) state_nxt = ST_WAIT;
      ST_DISABLED: if (chg_enable) state_nxt = ST_WAIT;
      default: state_nxt = ST_OFF;
    endcase
    if (state_r != ST_OFF && (!comp_db.vin_uv_ok || comp_db.vin_ov)) state_nxt = ST_OFF;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ntc_present_r <= 1'b0;
      sw_present_r <= 1'b0;
    end else if (state_r == ST_CONFIG) begin
      ntc_present_r <= !comp_db.ntc_grounded;
      sw_present_r <= comp_db.sw_detect;
    end
  end

  logic presence_valid;
  assign presence_valid = (state_r != ST_OFF) && (state_r != ST_CONFIG);

  // ****************************************
  // Die temperature foldback
  // ****************************************
  logic [3:0] fold_cur_r;
  logic fold_active_r;
  logic die_m1_rise, die_m2_rise;
  logic [3:0] prog_cur;
  assign prog_cur = chg_cur_r[3:0];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      fold_active_r <= 1'b0;
      fold_cur_r <= CUR_MIN_CODE;
    end else if (!foldback_en) begin
      fold_active_r <= 1'b0;
    end else if (!comp_db.die_warn) begin
      fold_active_r <= 1'b0;
    end else if (die_m2_rise) begin
      fold_active_r <= 1'b1;
      fold_cur_r <= CUR_MIN_CODE;
    end else if (die_m1_rise) begin
      fold_active_r <= 1'b1;
      fold_cur_r <= (prog_cur > CUR_FOLD_STEPS) ? prog_cur - CUR_FOLD_STEPS : CUR_MIN_CODE;
    end
  end

  // ****************************************
  // Charge control outputs
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ctl <= '0;
    end else begin
      o_ctl.charge_on <= (state_r == ST_ACTIVE) && !comp_db.die_sd && !ntc_gone;
      o_ctl.reduced_mode <= reduced_band;
      if (reduced_band) begin
        o_ctl.current_code <= ntc_set1_r[3:0];
        o_ctl.voltage_code <= ntc_set1_r[7:4];
      end else begin
        o_ctl.current_code <= fold_active_r ? fold_cur_r : prog_cur;
        o_ctl.voltage_code <= chg_cur_r[7:4];
      end
      o_ctl.trans_on <= comp_db.vin_uv_ok && !comp_db.vin_ov && ctrl2_r[CTRL2_TRANS_EN];
    end
  end
  assign o_state = state_r;

  // ****************************************
  // Event detection
  // ****************************************
  comp_s comp_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      comp_q <= '0;
    end else begin
      comp_q <= comp_db;
    end
  end

  logic ntc_cross, state_change;
  assign die_m1_rise = comp_db.die_m1 && !comp_q.die_m1;
  assign die_m2_rise = comp_db.die_m2 && !comp_q.die_m2;
  assign ntc_cross = ntc_monitor && (
    (comp_db.ntc_cold ^ comp_q.ntc_cold) || (comp_db.ntc_chilly ^ comp_q.ntc_chilly) ||
    (comp_db.ntc_warm ^ comp_q.ntc_warm) || (comp_db.ntc_hot ^ comp_q.ntc_hot));
  assign state_change = state_nxt != state_r;

  logic [7:0] set_stat, set_chg1, set_chg2;
  always_comb begin
    set_stat = '0;
    set_chg1 = '0;
    set_chg2 = '0;
    set_stat[EVTS_STATE_CHG] = state_change;
    set_chg1[EVT1_DIE_WARN] = comp_db.die_warn && !comp_q.die_warn;
    set_chg1[EVT1_DIE_M1] = foldback_en && die_m1_rise;
    set_chg1[EVT1_DIE_M2] = foldback_en && die_m2_rise;
    set_chg1[EVT1_NTC_CROSS] = ntc_cross;
    set_chg1[EVT1_NTC_GONE] = ntc_gone && !(comp_q.ntc_removed && ntc_check_en);
    set_chg1[EVT1_DIE_SD] = comp_db.die_sd && !comp_q.die_sd;
    set_chg1[EVT1_BATT_RMV] = (state_r == ST_ACTIVE) && (state_nxt == ST_FAULT) && ntc_gone;
  end

  // ****************************************
  // Read-to-clear event registers
  // ****************************************
  logic [7:0] evt_r [4];
  logic [7:0] set_all [4];
  logic [7:0] msk_all [4];
  logic [7:0] addr_all [4];
  assign set_all = '{set_stat, set_chg1, set_chg2, i_boost_evt};
  assign msk_all = '{state_event_mask_reg_r, chg_msk1_r, chg_msk2_r, boost_event_mask_reg_r};
  assign addr_all = '{ADDR_STAT_EVT, ADDR_CHG_EVT1, ADDR_CHG_EVT2, ADDR_BST_EVT};

  logic [3:0] new_evt;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_evt
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          evt_r[gi] <= '0;
        end else if (i_rd && i_addr == addr_all[gi]) begin
          evt_r[gi] <= set_all[gi];
        end else begin
          evt_r[gi] <= evt_r[gi] | set_all[gi];
        end
      end
      assign new_evt[gi] = |(set_all[gi] & ~msk_all[gi]);
    end
  endgenerate

  logic pending;
  assign pending = |{evt_r[0], evt_r[1], evt_r[2], evt_r[3]};

  // ****************************************
  // Status pin pulse
  // ****************************************
  // A pulse is armed once per burst; it re-arms only after every event
  // register has been read empty, so a busy host sees a single edge.
  localparam int PW = $clog2(PULSE_CYCLES + 1);
  logic [PW-1:0] pulse_cnt_r;
  logic armed_r;
  logic fire;
  assign fire = armed_r && !global_mask && (|new_evt);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      armed_r <= 1'b1;
    end else if (fire) begin
      armed_r <= 1'b0;
    end else if (!pending) begin
      armed_r <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_cnt_r <= '0;
    end else if (fire) begin
      pulse_cnt_r <= PW'(PULSE_CYCLES);
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end
  end

  logic rest_low;
  assign rest_low = (state_r == ST_ACTIVE) || (state_r == ST_WAIT);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flag <= 1'b1;
    end else begin
      o_flag <= (!rest_low) ^ (pulse_cnt_r != '0);
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  logic [7:0] status_val, temp_val;
  always_comb begin
    status_val = '0;
    status_val[2:0] = state_r;
    status_val[STAT_NTC_PRES] = presence_valid && ntc_present_r;
    status_val[STAT_SW_PRES] = presence_valid && sw_present_r;
    status_val[STAT_STATUS_SUM] = |evt_r[0];
    status_val[STAT_FAULT_SUM] = |{evt_r[1], evt_r[2], evt_r[3]};
    // die warm sense bit
    // Sense bits bypass the filter so the host sees the comparators as they are now.
    temp_val = {1'b0, i_comp.die_warn, i_comp.ntc_removed, i_comp.ntc_grounded,
                i_comp.ntc_hot, i_comp.ntc_warm, i_comp.ntc_chilly, i_comp.ntc_cold};
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_STATUS: o_rdata <= status_val;
        ADDR_CTRL1: o_rdata <= ctrl1_r;
        ADDR_CTRL2: o_rdata <= ctrl2_r;
        ADDR_CHG_CUR: o_rdata <= chg_cur_r;
        ADDR_NTC_SET1: o_rdata <= ntc_set1_r;
        ADDR_NTC_SET2: o_rdata <= ntc_set2_r;
        ADDR_STAT_EVT: o_rdata <= evt_r[0];
        ADDR_CHG_EVT1: o_rdata <= evt_r[1];
        ADDR_CHG_EVT2: o_rdata <= evt_r[2];
        ADDR_BST_EVT: o_rdata <= evt_r[3];
        ADDR_STATE_EVENT_MASK_REG: o_rdata <= state_event_mask_reg_r;
        ADDR_CHG_MSK1: o_rdata <= chg_msk1_r;
        ADDR_CHG_MSK2: o_rdata <= chg_msk2_r;
        ADDR_BOOST_EVENT_MASK_REG: o_rdata <= boost_event_mask_reg_r;
        ADDR_INPUT_SNS: o_rdata <= {6'h00, i_comp.vin_ov, i_comp.vin_uv_ok};
        ADDR_BATT_SNS: o_rdata <= {6'h00, i_comp.charge_done, i_comp.bat_present};
        ADDR_TEMPERATURE_SENSE_REG: o_rdata <= temp_val;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ---- cter_core_asserts.sv ----
// Port-level checker for the charger thermal event block.
`timescale 1ns/100ps
`default_nettype none
module cter_core_asserts
  import cter_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = 500,
  parameter int PULSE_CYCLES = 5000
) (
  input wire logic i_core_clk, // Clock.
  input wire logic i_rst, // Reset.
  input wire logic [7:0] i_addr, // Address.
  input wire logic [7:0] i_wdata, // Write data.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  input wire logic [7:0] o_rdata, // Read data.
  input wire comp_s i_comp, // Comparators.
  input wire logic [7:0] i_boost_evt, // Boost events.
  input wire chg_ctl_s o_ctl, // Charge control.
  input wire logic o_flag, // Status pin.
  input wire chg_state_e o_state // State code.
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic rest;
  int bad_cnt, sd_cnt, off_cnt, ntc_cnt, rm_cnt;
  assign rest = !(o_state inside {ST_ACTIVE, ST_WAIT});
  // The sd, off, ntc and rm counters hold how long a raw condition has lasted, so their limits allow the filter delay.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bad_cnt <= 0;
      sd_cnt <= 0;
      off_cnt <= 0;
      ntc_cnt <= 0;
      rm_cnt <= 0;
    end else begin
      bad_cnt <= (o_flag != rest) ? bad_cnt + 1 : 0;
      sd_cnt <= i_comp.die_sd ? sd_cnt + 1 : 0;
      off_cnt <= (!i_comp.vin_uv_ok || i_comp.vin_ov) ? off_cnt + 1 : 0;
      ntc_cnt <= ((i_comp.ntc_cold || i_comp.ntc_hot) && !i_comp.ntc_grounded) ? ntc_cnt + 1 : 0;
      rm_cnt <= (i_comp.ntc_removed && !i_comp.ntc_grounded) ? rm_cnt + 1 : 0;
    end
  end
  a_input_sense: assert property (
    $past(i_rd) && $past(i_addr) == ADDR_INPUT_SNS |->
    o_rdata == {6'h00, $past(i_comp.vin_ov), $past(i_comp.vin_uv_ok)})
    else $error("input sense read differs from comparators");
  a_batt_sense: assert property (
    $past(i_rd) && $past(i_addr) == ADDR_BATT_SNS |->
    o_rdata == {6'h00, $past(i_comp.charge_done), $past(i_comp.bat_present)})
    else $error("battery sense read differs from comparators");
  a_temp_sense: assert property (
    $past(i_rd) && $past(i_addr) == ADDR_TEMPERATURE_SENSE_REG |->
    o_rdata == {1'b0, $past(i_comp.die_warn), $past(i_comp.ntc_removed),
    $past(i_comp.ntc_grounded), $past(i_comp.ntc_hot), $past(i_comp.ntc_warm),
    $past(i_comp.ntc_chilly), $past(i_comp.ntc_cold)})
    else $error("temperature sense read differs from comparators");
  a_pulse_bound: assert property (bad_cnt <= PULSE_CYCLES + 4)
    else $error("status pin away from resting level too long");
  a_sd_halt: assert property (sd_cnt > DEBOUNCE_CYCLES + 4 |-> !o_ctl.charge_on)
    else $error("charging while die shutdown is present");
  a_trans_window: assert property (off_cnt > DEBOUNCE_CYCLES + 4 |-> !o_ctl.trans_on)
    else $error("transceiver supply on outside input window");
  a_off_state: assert property (off_cnt > DEBOUNCE_CYCLES + 4 |-> o_state == ST_OFF)
    else $error("state not off outside input window");
  a_ntc_halt: assert property (ntc_cnt > DEBOUNCE_CYCLES + 4 |-> !o_ctl.charge_on)
    else $error("charging beyond cold or hot threshold");
  a_removed_halt: assert property (rm_cnt > DEBOUNCE_CYCLES + 4 |-> !o_ctl.charge_on)
    else $error("charging with thermistor removed");
  c_pulse: cover property (o_flag != rest);
  c_fault: cover property (o_state == ST_FAULT);
  c_sense: cover property ($past(i_rd) && $past(i_addr) == ADDR_INPUT_SNS);
endmodule
bind cter_core cter_core_asserts #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .PULSE_CYCLES(PULSE_CYCLES))
  chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_comp(i_comp), .i_boost_evt(i_boost_evt), .o_ctl(o_ctl),
  .o_flag(o_flag), .o_state(o_state));
`default_nettype wire

// ---- cter_host_model.sv ----
// Host model that senses the status pin and measures its pulses.
`timescale 1ns/100ps
`default_nettype none
module cter_host_model
  import cter_pkg::*;
(
  input wire logic i_core_clk, // Clock.
  input wire logic i_rst, // Reset.
  input wire logic i_flag, // Status pin.
  input wire chg_state_e i_state, // State code, gives resting level.
  output int o_pulses, // Pulses seen.
  output int o_width // Width of the last pulse.
);
  int run;
  // a pulse is the pin away from its resting level.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pulses = 0;
      o_width = 0;
      run = 0;
    end else if (i_flag != !(i_state inside {ST_ACTIVE, ST_WAIT})) begin
      run = run + 1;
    end else begin
      // A one-cycle lag behind a state change is not taken as a pulse.
      if (run > 1) begin
        o_pulses = o_pulses + 1;
        o_width = run;
      end
      run = 0;
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the charger thermal event block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cter_pkg::*;
  logic i_core_clk, i_rst, i_wr, i_rd;
  logic [7:0] i_addr, i_wdata, o_rdata, i_boost_evt, v;
  comp_s i_comp;
  chg_ctl_s o_ctl;
  logic o_flag;
  chg_state_e o_state;
  int failures, n_tests, pulses, width, p0;
  cter_core #(.DEBOUNCE_CYCLES(2), .PULSE_CYCLES(4)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_comp(i_comp), .i_boost_evt(i_boost_evt), .o_ctl(o_ctl), .o_flag(o_flag), .o_state(o_state));
  cter_host_model host (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_flag(o_flag),
    .i_state(o_state), .o_pulses(pulses), .o_width(width));
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    cyc(1);
    i_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    cyc(1);
    i_rd <= 1'b0;
    #1 v = o_rdata;
    cyc(1);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(v & m, e);
  endtask
  // Event registers clear on read, which also re-arms the pin.
  task automatic clr();
    for (int a = 6; a < 10; a++) rd(a[7:0]);
    p0 = pulses;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    failures++;
    end_of_test();
  end
  initial begin
    failures = 0;
    n_tests = 0;
    i_rst = 1'b1;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_boost_evt = 8'h00;
    i_comp = '0;
    i_comp.vin_uv_ok = 1'b1;
    i_comp.bat_present = 1'b1;
    cyc(3);
    i_rst <= 1'b0;
    cyc(40);
    rc(ADDR_CTRL1, 8'hff, CTRL1_RST);
    rc(ADDR_CTRL2, 8'hff, CTRL2_RST);
    rc(8'h20, 8'hff, 8'h00);
    rc(ADDR_STATUS, 8'h30, 8'h20);
    rc(ADDR_BATT_SNS, 8'h03, 8'h01);
    for (int k = 0; k < 4; k++) begin
      i_comp.vin_ov <= k[1];
      i_comp.vin_uv_ok <= k[0];
      cyc(1);
      rc(ADDR_INPUT_SNS, 8'hff, k[7:0]);
    end
    cyc(10);
    chk({7'h00, o_ctl.trans_on}, 8'h00);
    i_comp.vin_ov <= 1'b0;
    cyc(40);
    wr(ADDR_CHG_CUR, 8'h05);
    wr(ADDR_CTRL1, CTRL1_RST | 8'h02);
    clr();
    i_comp.die_warn <= 1'b1;
    cyc(10);
    rc(ADDR_TEMPERATURE_SENSE_REG, 8'hff, 8'h40);
    rc(ADDR_STATUS, 8'h80, 8'h80);
    i_comp.die_m1 <= 1'b1;
    cyc(10);
    chk({4'h0, o_ctl.current_code}, 8'h03);
    i_comp.die_m2 <= 1'b1;
    cyc(10);
    chk({4'h0, o_ctl.current_code}, 8'h00);
    chk(8'(pulses - p0), 8'h01);
    rc(ADDR_CHG_EVT1, 8'hff, 8'h0e);
    rc(ADDR_CHG_EVT1, 8'hff, 8'h00);
    i_comp.die_m2 <= 1'b0;
    i_comp.die_m1 <= 1'b0;
    i_comp.die_warn <= 1'b0;
    cyc(10);
    chk({4'h0, o_ctl.current_code}, 8'h05);
    wr(ADDR_CTRL1, CTRL1_RST);
    i_comp.die_warn <= 1'b1;
    i_comp.die_m1 <= 1'b1;
    cyc(10);
    chk({4'h0, o_ctl.current_code}, 8'h05);
    i_comp.die_m1 <= 1'b0;
    i_comp.die_warn <= 1'b0;
    cyc(10);
    wr(ADDR_CTRL1, CTRL1_RST | 8'h10);
    clr();
    i_comp.die_warn <= 1'b1;
    cyc(15);
    chk(8'(pulses - p0), 8'h00);
    i_comp.die_warn <= 1'b0;
    cyc(10);
    wr(ADDR_CTRL1, CTRL1_RST);
    wr(ADDR_CHG_MSK1, 8'h02);
    clr();
    i_comp.die_warn <= 1'b1;
    cyc(15);
    chk(8'(pulses - p0), 8'h00);
    i_comp.die_warn <= 1'b0;
    wr(ADDR_CHG_MSK1, 8'h00);
    i_comp.die_sd <= 1'b1;
    cyc(10);
    chk({7'h00, o_ctl.charge_on}, 8'h00);
    i_comp.die_sd <= 1'b0;
    // Dropping the input briefly takes the state machine out of fault for a restart.
    i_comp.vin_uv_ok <= 1'b0;
    cyc(10);
    i_comp.vin_uv_ok <= 1'b1;
    i_comp.ntc_cold <= 1'b1;
    cyc(10);
    rc(ADDR_CHG_EVT1, 8'h10, 8'h10);
    i_comp.ntc_cold <= 1'b0;
    wr(ADDR_CTRL1, CTRL1_RST | 8'h04);
    wr(ADDR_NTC_SET1, 8'h51);
    i_comp.ntc_warm <= 1'b1;
    cyc(10);
    chk({2'h0, o_ctl.charge_on, o_ctl.reduced_mode, o_ctl.current_code}, 8'h31);
    chk({4'h0, o_ctl.voltage_code}, 8'h05);
    wr(ADDR_CTRL1, CTRL1_RST);
    cyc(10);
    chk({7'h00, o_ctl.charge_on}, 8'h00);
    i_comp.ntc_warm <= 1'b0;
    cyc(10);
    i_comp.ntc_removed <= 1'b1;
    cyc(20);
    chk({5'h00, o_state}, {5'h00, ST_FAULT});
    chk({7'h00, o_ctl.charge_on}, 8'h00);
    rc(ADDR_CHG_EVT1, 8'h01, 8'h01);
    end_of_test();
  end
endmodule
`default_nettype wire
